// *** design/fifo_if.sv ***
// Purpose: Push and pop signals of one word FIFO
// Assumes: Single clock domain
// Notes: Carries data and full and empty flags; in loopback the port forces transmit empty and receive full set towards the link engine
`timescale 1ns/10ps
interface fifo_if #(parameter int W = 16);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic [W-1:0] rdata;
  logic full;
  logic empty;
  modport owner (input push, input wdata, input pop, output rdata, output full, output empty);
  modport user (output push, output wdata, output pop, input rdata, input full, input empty);
endinterface

// *** design/link_shifter.sv ***
// Purpose: Shift engine facing the serial link, sampled on the system clock
// Assumes: Link clock is produced by the peripheral, mode 0 framing
// Notes: Frame width 4 to 16; MSB first
`timescale 1ns/10ps
module link_shifter (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_enable,
  input wire logic [4:0] i_width,
  // Synchronised link pins
  input wire logic i_sck,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  output logic o_miso,
  // FIFOs
  fifo_if.user tx,
  fifo_if.user rx,
  output logic o_overrun,
  output logic o_busy
);
  logic sck_q;
  logic sel_q;
  logic [15:0] sh_q;
  logic [15:0] out_q;
  logic [4:0] bits_q;
  logic rise;
  logic fall;
  logic done;

  assign rise = i_sck && !sck_q;
  assign fall = !i_sck && sck_q;
  assign done = rise && !i_sel_n && (bits_q + 5'h01 == i_width);
  assign tx.wdata = '0;
  assign tx.push = 1'b0;
  assign rx.pop = 1'b0;
  assign rx.push = done && i_enable && !rx.full;
  assign rx.wdata = {sh_q[14:0], i_mosi} & 16'((17'h00001 << i_width) - 17'h00001);
  assign tx.pop = i_enable && !i_sel_n && sel_q && !tx.empty;
  assign o_overrun = done && i_enable && rx.full;
  assign o_busy = !i_sel_n;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sck_q <= 1'b0;
      // Idle level of the select pin, so no false select edge follows reset
      sel_q <= 1'b1;
      sh_q <= '0;
      out_q <= '0;
      bits_q <= '0;
      o_miso <= 1'b0;
    end else begin
      sck_q <= i_sck;
      sel_q <= i_sel_n;
      if (!i_enable || i_sel_n) begin
        bits_q <= '0;
      end else if (rise) begin
        sh_q <= {sh_q[14:0], i_mosi};
        bits_q <= done ? 5'h00 : bits_q + 5'h01;
      end
      if (tx.pop) begin
        out_q <= tx.rdata << (5'h10 - i_width);
      end else if (fall) begin
        out_q <= {out_q[14:0], 1'b0};
      end
      o_miso <= i_enable ? out_q[15] : 1'b0;
    end
  end
endmodule // link_shifter

// *** design/sync_serial_pkg.sv ***
// Purpose: Shared constants for the synchronous serial port register block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Offsets and field positions used by the top, its assertions and the bench
package sync_serial_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int MIN_FRAME = 4;
  localparam int MAX_FRAME = 16;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_RAW = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_MIS = 8'h14;
  localparam logic [7:0] OFF_ICLR = 8'h18;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WID_LSB = 4;
  localparam int CTRL_LOOP_BIT = 1;
  localparam logic [4:0] RST_WIDTH = 5'h08;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_TO = 2;
  localparam int IRQ_OR = 3;
  localparam int TIMEOUT_BITS = 32;
  localparam int STAT_TNF = 0;
  localparam int STAT_RNE = 1;
  localparam int STAT_BSY = 2;
endpackage

// *** design/sync_serial_port.sv ***
// Purpose: Data FIFO access, enable and interrupt logic of a synchronous serial port
// Assumes: Classic Wishbone, link pins from another clock domain
// Notes: One wait state per access; ack one cycle after stb
`timescale 1ns/10ps
module sync_serial_port
  #(
  parameter int TIMEOUT_CYC = 256
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Serial link
  input wire logic i_sck,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  output logic o_miso,
  // Interrupt
  output logic o_irq
);
  import sync_serial_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pin_meta_q <= 3'h2;
      pin_sync_q <= 3'h2;
    end else begin
      pin_meta_q <= {i_mosi, i_sel_n, i_sck};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic enable_q;
  logic loop_q;
  logic [4:0] width_q;
  logic [3:0] mask_q;
  logic [3:0] raw_q;
  logic [3:0] masked;
  logic [31:0] tcnt_q;
  logic ack_q;
  logic req;
  logic wr;
  logic rd;
  logic overrun;
  logic busy;
  logic [4:0] width_wr;
  logic [4:0] width_eff;
  logic [15:0] width_mask;

  fifo_if #(.W(DATA_W)) tx_f ();
  fifo_if #(.W(DATA_W)) rx_f ();
  fifo_if #(.W(DATA_W)) rx_pri ();

  assign req = i_wb_cyc && i_wb_stb && !ack_q;
  assign wr = req && i_wb_we;
  assign rd = req && !i_wb_we;
  assign width_wr = i_wb_dat[CTRL_WID_LSB +: 5];
  assign width_eff = (width_q < 5'(MIN_FRAME)) ? 5'(MIN_FRAME) :
                     (width_q > 5'(MAX_FRAME)) ? 5'(MAX_FRAME) : width_q;
  assign width_mask = 16'((17'h00001 << width_eff) - 17'h00001);

  // ****************************************
  // FIFOs
  // ****************************************
  // Eight-entry transmit buffer
  word_fifo #(.DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_flush(1'b0),
    .f(tx_f)
  );

  word_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_flush(1'b0),
    .f(rx_f)
  );

  assign tx_f.push = wr && (i_wb_adr == OFF_DATA) && i_wb_sel[0];
  assign tx_f.wdata = i_wb_dat[15:0] & width_mask;
  assign rx_f.pop = rd && (i_wb_adr == OFF_DATA) && !rx_f.empty;
  assign rx_f.push = rx_pri.push;
  assign rx_f.wdata = rx_pri.wdata;
  assign rx_pri.rdata = rx_f.rdata;
  assign rx_pri.full = rx_f.full;
  assign rx_pri.empty = rx_f.empty;

  logic tx_pop_shift;
  logic tx_pop_loop;
  assign tx_pop_loop = loop_q && enable_q && !tx_f.empty && !rx_f.full;

  // ****************************************
  // Link engine
  // ****************************************
  fifo_if #(.W(DATA_W)) tx_eng ();
  assign tx_eng.rdata = tx_f.rdata;
  assign tx_eng.full = tx_f.full;
  assign tx_eng.empty = tx_f.empty || loop_q;
  assign tx_pop_shift = tx_eng.pop;
  assign tx_f.pop = tx_pop_shift || tx_pop_loop;

  fifo_if #(.W(DATA_W)) rx_eng ();
  assign rx_eng.rdata = rx_f.rdata;
  assign rx_eng.full = rx_f.full || loop_q;
  assign rx_eng.empty = rx_f.empty;
  assign rx_pri.push = rx_eng.push || tx_pop_loop;
  assign rx_pri.wdata = tx_pop_loop ? tx_f.rdata : rx_eng.wdata;
  assign rx_pri.pop = 1'b0;

  logic miso_w;
  link_shifter u_shift (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_enable(enable_q),
    .i_width(width_eff),
    .i_sck(pin_sync_q[0]),
    .i_sel_n(pin_sync_q[1]),
    .i_mosi(pin_sync_q[2]),
    .o_miso(miso_w),
    .tx(tx_eng),
    .rx(rx_eng),
    .o_overrun(overrun),
    .o_busy(busy)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_miso <= 1'b0;
    end else begin
      o_miso <= miso_w;
    end
  end

  // ****************************************
  // Control and mask registers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      enable_q <= 1'b0;
      loop_q <= 1'b0;
      width_q <= RST_WIDTH;
      mask_q <= 4'h0;
    end else if (wr && i_wb_sel[0]) begin
      if (i_wb_adr == OFF_CTRL) begin
        enable_q <= i_wb_dat[CTRL_EN_BIT];
        loop_q <= i_wb_dat[CTRL_LOOP_BIT];
        if (!enable_q) begin
          width_q <= width_wr;
        end
      end
      if (i_wb_adr == OFF_MASK) begin
        mask_q <= i_wb_dat[3:0];
      end
    end
  end

  // ****************************************
  // Interrupt sources
  // ****************************************
  logic to_event;
  logic or_event;
  logic clr_wr;
  logic tcnt_run;
  assign clr_wr = wr && i_wb_sel[0] && (i_wb_adr == OFF_ICLR);
  assign tcnt_run = !(rx_f.empty || rx_f.push || rx_f.pop || busy);
  // One pulse as the idle count reaches its end, so a later clear sticks
  assign to_event = enable_q && tcnt_run && (tcnt_q == 32'(TIMEOUT_CYC - 2));
  assign or_event = overrun;

  // Receive idle counter restarts on any receive activity
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tcnt_q <= '0;
    end else if (rx_f.empty || rx_f.push || rx_f.pop || busy) begin
      tcnt_q <= '0;
    end else if (tcnt_q != 32'(TIMEOUT_CYC - 1)) begin
      tcnt_q <= tcnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      raw_q <= 4'h0;
    end else begin
      // Service levels: tx not full while enabled, rx not empty
      raw_q[IRQ_TX] <= enable_q && (tx_f.empty || !tx_f.full);
      raw_q[IRQ_RX] <= !rx_f.empty;
      raw_q[IRQ_TO] <= to_event || (raw_q[IRQ_TO] && !(clr_wr && i_wb_dat[IRQ_TO]));
      raw_q[IRQ_OR] <= or_event || (raw_q[IRQ_OR] && !(clr_wr && i_wb_dat[IRQ_OR]));
    end
  end

  // Masked state is raw AND mask
  assign masked = raw_q & mask_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |masked;
    end
  end

  // ****************************************
  // Wishbone read and ack
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      ack_q <= req;
      o_wb_dat <= '0;
      if (rd) begin
        unique case (i_wb_adr)
          OFF_DATA: o_wb_dat <= rx_f.empty ? 32'h00000000 : {16'h0000, rx_f.rdata & width_mask};
          OFF_CTRL: o_wb_dat <= {23'h000000, width_q, 2'h0, loop_q, enable_q};
          OFF_STAT: o_wb_dat <= {29'h00000000, busy, !rx_f.empty, !tx_f.full};
          OFF_RAW: o_wb_dat <= {28'h0000000, raw_q};
          OFF_MASK: o_wb_dat <= {28'h0000000, mask_q};
          OFF_MIS: o_wb_dat <= {28'h0000000, masked};
          default: o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end

  assign o_wb_ack = ack_q;
endmodule // sync_serial_port

// *** design/word_fifo.sv ***
// Purpose: Flip-flop FIFO of fixed width and depth
// Assumes: Push when full and pop when empty are ignored
// Notes: Depth must be a power of two
`timescale 1ns/10ps
module word_fifo #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  // Port
  fifo_if.owner f
);
  localparam int AW = $clog2(DEPTH);
  logic [$bits(f.wdata)-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign do_push = f.push && (cnt_q != (AW+1)'(DEPTH));
  assign do_pop = f.pop && (cnt_q != '0);
  assign f.full = (cnt_q == (AW+1)'(DEPTH));
  assign f.empty = (cnt_q == '0);
  assign f.rdata = mem_q[rp_q];

  always_ff @(posedge i_ref_clk) begin
    if (do_push) begin
      mem_q[wp_q] <= f.wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // word_fifo

// *** sim/link_peer.sv ***
// Purpose: Peripheral that clocks frames into the port
// Assumes: Mode 0, MSB first, 160 ns link clock
// Notes: Link clock stands low outside frames
`timescale 1ns/10ps
module link_peer (
  // Link pins
  output logic o_sck,
  output logic o_sel_n,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sck = 1'b0;
    o_sel_n = 1'b1;
    o_mosi = 1'b1;
  end
  task automatic frame(input logic [15:0] v, input int n, output logic [15:0] got);
    got = 16'h0;
    o_sel_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi <= v[i];
      #80 o_sck <= 1'b1;
      got = {got[14:0], i_miso};
      #80 o_sck <= 1'b0;
    end
    // Released data line shows the inverse of its last bit
    #80 o_sel_n <= 1'b1;
    o_mosi <= ~o_mosi;
    // Hold deselect so back-to-back frames stay apart
    #80;
  endtask
endmodule // link_peer

// *** sim/sync_serial_sva.sv ***
// Purpose: Port checks of the serial port register block
// Assumes: One clock, synchronous active-low reset
// Notes: Enable and mask are tracked from bus writes
`timescale 1ns/10ps
module sync_serial_sva #(
  parameter int TIMEOUT_CYC = 256
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Link and interrupt
  input wire logic i_sck,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  input wire logic o_miso,
  input wire logic o_irq
);
  import sync_serial_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic wr_ok;
  logic rd_ok;
  logic en_q;
  logic [3:0] mask_q;
  assign wr_ok = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] && o_wb_ack;
  assign rd_ok = i_wb_cyc && i_wb_stb && !i_wb_we && o_wb_ack;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) mask_q <= 4'h0;
    else if (wr_ok && i_wb_adr == OFF_MASK) mask_q <= i_wb_dat[3:0];
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) en_q <= 1'b0;
    else if (wr_ok && i_wb_adr == OFF_CTRL) en_q <= i_wb_dat[CTRL_EN_BIT];
  end
  chk_ack_follows_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing after request");
  chk_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_dat_only_ack: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data without ack");
  chk_data_rd_trim: assert property (rd_ok && i_wb_adr == OFF_DATA |-> o_wb_dat[31:16] == 16'h0)
    else $error("data read above width");
  chk_raw_four_bits: assert property (rd_ok && (i_wb_adr == OFF_RAW || i_wb_adr == OFF_MIS)
    |-> o_wb_dat[31:4] == 28'h0)
    else $error("status field too wide");
  chk_mis_is_masked: assert property (rd_ok && i_wb_adr == OFF_MIS |-> (o_wb_dat[3:0] & ~mask_q) == 4'h0)
    else $error("masked view shows masked-off bit");
  chk_irq_masked_off: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !o_irq)
    else $error("irq with all sources masked");
  chk_miso_idle_off: assert property (!en_q && !$past(en_q) |-> !o_miso)
    else $error("serial out active while disabled");
  cover property (o_irq);
  cover property (rd_ok && i_wb_adr == OFF_DATA && o_wb_dat != 32'h0);
  cover property (wr_ok && i_wb_adr == OFF_ICLR);
endmodule // sync_serial_sva

bind sync_serial_port sync_serial_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) sync_serial_sva_i (.i_ref_clk,
  .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat,
  .o_wb_ack, .i_sck, .i_sel_n, .i_mosi, .o_miso, .o_irq);

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench of the serial port block
// Assumes: Classic Wishbone master, random data with fixed seed
// Notes: Short receive timeout of 16 cycles
`timescale 1ns/10ps
module tb_top;
  import sync_serial_pkg::*;
  logic clk, rst_n, cyc, stb, we, ack, irq, sck, sel_n, mosi, miso;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r, d;
  logic [15:0] got;
  int err_count, n_checks, seed, w;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  sync_serial_port #(.TIMEOUT_CYC(16)) sync_serial_port_i (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sck(sck), .i_sel_n(sel_n),
    .i_mosi(mosi), .o_miso(miso), .o_irq(irq));
  link_peer link_peer_i (.o_sck(sck), .o_sel_n(sel_n), .o_mosi(mosi), .i_miso(miso));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] trim(input logic [31:0] v, input int n);
    return v & ((32'h1 << n) - 32'h1);
  endfunction
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= a; wdat <= v;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic cfg(input int n, input logic lp, input logic en);
    wb(1'b1, OFF_CTRL, 32'h0);
    wb(1'b1, OFF_CTRL, (32'(n) << CTRL_WID_LSB) | (32'(lp) << CTRL_LOOP_BIT));
    if (en) wb(1'b1, OFF_CTRL, (32'(n) << CTRL_WID_LSB) | (32'(lp) << CTRL_LOOP_BIT) | 32'h1);
  endtask
  initial begin
    seed = 80219; err_count = 0; n_checks = 0;
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'hF; wdat = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, OFF_CTRL, 32'h0); chk(r, {23'h0, RST_WIDTH, 4'h0});
    wb(1'b0, OFF_STAT, 32'h0); chk(r, 32'h1);
    wb(1'b0, 8'h40, 32'h0); chk(r, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? MIN_FRAME : (i == 1) ? MAX_FRAME : MIN_FRAME + ($unsigned($random(seed)) % 13);
      d = $random(seed);
      cfg(w, 1'b1, 1'b1);
      wb(1'b1, OFF_DATA, d);
      wb(1'b0, OFF_STAT, 32'h0); chk({31'h0, r[STAT_RNE]}, 32'h1);
      wb(1'b0, OFF_DATA, 32'h0); chk(r, trim(d, w));
    end
    wb(1'b0, OFF_DATA, 32'h0); chk(r, 32'h0);
    $display("test loopback done");
    cfg(8, 1'b0, 1'b0);
    wb(1'b1, OFF_MASK, 32'h1); chk({31'h0, irq}, 32'h0);
    cfg(8, 1'b0, 1'b1); repeat (2) @(posedge clk); chk({31'h0, irq}, 32'h1);
    wb(1'b0, OFF_MIS, 32'h0); chk(r, 32'h1);
    wb(1'b1, OFF_MASK, 32'h4); repeat (2) @(posedge clk); chk({31'h0, irq}, 32'h0);
    $display("test irq done");
    wb(1'b1, OFF_DATA, 32'h00ABCD5A);
    d = $random(seed);
    link_peer_i.frame(d[15:0], 8, got);
    chk({16'h0, got}, 32'h5A);
    repeat (40) @(posedge clk);
    wb(1'b0, OFF_RAW, 32'h0); chk(r, 32'h7);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, OFF_ICLR, 32'h4);
    wb(1'b0, OFF_RAW, 32'h0); chk(r, 32'h3);
    wb(1'b0, OFF_MIS, 32'h0); chk(r, 32'h0);
    wb(1'b0, OFF_DATA, 32'h0); chk(r, trim(d, 8));
    $display("test link done");
    cfg(8, 1'b0, 1'b0);
    link_peer_i.frame(16'h00A5, 8, got);
    chk({16'h0, got}, 32'h0);
    for (int i = 0; i < 9; i++) wb(1'b1, OFF_DATA, $random(seed));
    wb(1'b0, OFF_STAT, 32'h0); chk(r, 32'h0);
    $display("test full done");
    cfg(8, 1'b0, 1'b1);
    for (int i = 0; i < 9; i++) begin
      link_peer_i.frame(16'h0030 + 16'(i), 8, got);
    end
    repeat (40) @(posedge clk);
    wb(1'b0, OFF_RAW, 32'h0);
    chk(r, 32'hF);
    wb(1'b1, OFF_ICLR, 32'h8);
    wb(1'b0, OFF_RAW, 32'h0);
    chk(r, 32'h7);
    wb(1'b1, OFF_ICLR, 32'h4);
    wb(1'b0, OFF_RAW, 32'h0);
    chk(r, 32'h3);
    wb(1'b0, OFF_STAT, 32'h0);
    chk(r, 32'h3);
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, OFF_DATA, 32'h0);
      chk(r, 32'h30 + 32'(i));
    end
    wb(1'b0, OFF_DATA, 32'h0);
    chk(r, 32'h0);
    $display("test overrun done");
    end_of_test();
  end
endmodule // tb_top
